// >>> ssm_consts.svh
// Constants for the serial port control block: mode codes, reset values and timing.
`ifndef SSM_CONSTS_SVH
`define SSM_CONSTS_SVH

// ----------------------------------------------------------------------------
// Slave-select mode codes
// ----------------------------------------------------------------------------
`define SSM_MODE_3WIRE      2'h0
`define SSM_MODE_4WIRE_IN   2'h1
`define SSM_MODE_MASTER_BIT 1

// ----------------------------------------------------------------------------
// Field widths and reset values
// ----------------------------------------------------------------------------
`define SSM_DATA_W          8
`define SSM_BIT_LAST        3'h7
`define SSM_TX_EMPTY_RST    1'b1
`define SSM_BYTE_RST        8'h00
// The serial clock bit resets low, its idle level, so no false edge follows reset.
`define SSM_SYNC_RST        4'h8

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define SSM_CLK_MHZ         50
`define SSM_SCK_HALF_NS     100

`endif

// >>> ssm_pkg.sv
// Types shared by the serial port control block.
package ssm_pkg;

  typedef enum logic [1:0] {
    SSM_IDLE  = 2'b01,
    SSM_SHIFT = 2'b10
  } ssm_state_e;

endpackage : ssm_pkg

// >>> ssm_sync.sv
// Two-stage synchroniser for pin inputs, one per bit.
`timescale 1ns/1ps
`default_nettype none

module ssm_sync #(
  parameter int          WIDTH   = 4,
  parameter logic [3:0]  RST_VAL = 4'h0
) (
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  // Asynchronous inputs and their synchronised copies
  input  wire logic [WIDTH-1:0] d_i,
  output var  logic [WIDTH-1:0] q_o
);

  logic [WIDTH-1:0] meta_r;

  genvar g;
  generate
    for (g = 0; g < WIDTH; g++)
    begin : g_bit
      always_ff @(posedge clk_i)
      begin
        if (rst_i)
        begin
          meta_r[g] <= RST_VAL[g];
          q_o[g]    <= RST_VAL[g];
        end
        else
        begin
          meta_r[g] <= d_i[g];
          q_o[g]    <= meta_r[g];
        end
      end
    end
  endgenerate

endmodule : ssm_sync

`default_nettype wire

// >>> ssm_ctrl.sv
// Serial port control: slave-select modes, transmit buffer and a byte shift engine.
`timescale 1ns/1ps
`default_nettype none
`include "ssm_consts.svh"

module ssm_ctrl (
  // Clock and reset
  input  wire logic                   CLK_I,
  input  wire logic                   SRST_I,
  // Control bits
  input  wire logic [1:0]             MODE_I,
  input  wire logic                   ENABLE_I,
  input  wire logic                   MASTER_I,
  // Transmit buffer
  input  wire logic                   TX_WR_I,
  input  wire logic [`SSM_DATA_W-1:0] TX_DATA_I,
  output var  logic                   TX_EMPTY_O,
  // Received byte
  output var  logic [`SSM_DATA_W-1:0] RX_DATA_O,
  output var  logic                   RX_VALID_O,
  output var  logic                   BUSY_O,
  // Serial clock pin
  input  wire logic                   SCK_I,
  output var  logic                   SCK_O,
  output var  logic                   SCK_OE_O,
  // Master-out pin
  input  wire logic                   MOSI_I,
  output var  logic                   MOSI_O,
  output var  logic                   MOSI_OE_O,
  // Master-in pin
  input  wire logic                   MISO_I,
  output var  logic                   MISO_O,
  output var  logic                   MISO_OE_O,
  // Slave-select pin
  input  wire logic                   SSEL_I,
  output var  logic                   SSEL_O,
  output var  logic                   SSEL_OE_O
);

  // --------------------------------------------------------------------------
  // Timing
  // --------------------------------------------------------------------------
  localparam int        HALF_CYC_I = (`SSM_SCK_HALF_NS * `SSM_CLK_MHZ + 999) / 1000;
  localparam logic [7:0] HALF_LAST = 8'(HALF_CYC_I - 1);

  // --------------------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------------------
  logic [3:0] sync_q;
  logic       sck_s;
  logic       mosi_s;
  logic       miso_s;
  logic       ssel_s;
  logic       sck_d_r;

  ssm_sync #(
    .WIDTH   (4),
    .RST_VAL (`SSM_SYNC_RST)
  ) u_sync (
    .clk_i (CLK_I),
    .rst_i (SRST_I),
    .d_i   ({SSEL_I, MISO_I, MOSI_I, SCK_I}),
    .q_o   (sync_q)
  );

  assign sck_s  = sync_q[0];
  assign mosi_s = sync_q[1];
  assign miso_s = sync_q[2];
  assign ssel_s = sync_q[3];

  always_ff @(posedge CLK_I)
  begin
    if (SRST_I)
      sck_d_r <= 1'b0;
    else
      sck_d_r <= sck_s;
  end

  // --------------------------------------------------------------------------
  // Role decode
  // --------------------------------------------------------------------------
  ssm_pkg::ssm_state_e state_r;
  logic [`SSM_DATA_W-1:0] tx_buf_r;
  logic [`SSM_DATA_W-1:0] sh_r;
  logic                   tx_empty_r;
  logic                   samp_r;
  logic [2:0]             bit_r;
  logic [7:0]             div_r;
  logic                   sck_r;
  logic                   master_en;
  logic                   slave_sel;
  logic                   load;
  logic                   tick;
  logic                   rise;
  logic                   fall;
  logic                   last_fall;
  logic                   abort;
  logic                   in_bit;

  // A low select pin in mode 01 means another master owns the bus, so the
  // master role backs off rather than fight it.
  assign master_en = ENABLE_I & MASTER_I &
                     ~((MODE_I == `SSM_MODE_4WIRE_IN) & ~ssel_s);
  // Mode 00 has no select pin, so a three-wire slave is always selected.
  assign slave_sel = ENABLE_I & ~MASTER_I &
                     ((MODE_I == `SSM_MODE_3WIRE) |
                      ((MODE_I == `SSM_MODE_4WIRE_IN) & ~ssel_s));

  assign load  = (state_r == ssm_pkg::SSM_IDLE) & ((master_en & ~tx_empty_r) | slave_sel);
  assign tick  = (state_r == ssm_pkg::SSM_SHIFT) & master_en & (div_r == HALF_LAST);
  assign rise  = master_en ? (tick & ~sck_r) : (sck_s & ~sck_d_r);
  assign fall  = master_en ? (tick & sck_r) : (~sck_s & sck_d_r);
  assign in_bit = master_en ? miso_s : mosi_s;
  assign abort = ~(master_en | slave_sel);
  assign last_fall = (state_r == ssm_pkg::SSM_SHIFT) & ~abort & fall & (bit_r == `SSM_BIT_LAST);

  // --------------------------------------------------------------------------
  // Transmit buffer and empty flag
  // --------------------------------------------------------------------------
  // A write in the cycle of a load still clears the flag: the old byte has
  // left, but the new one is now waiting.
  always_ff @(posedge CLK_I)
  begin
    if (SRST_I)
    begin
      tx_buf_r   <= `SSM_BYTE_RST;
      tx_empty_r <= `SSM_TX_EMPTY_RST;
    end
    else if (TX_WR_I)
    begin
      tx_buf_r   <= TX_DATA_I;
      tx_empty_r <= 1'b0;
    end
    else if (load)
      tx_empty_r <= 1'b1;
  end

  assign TX_EMPTY_O = tx_empty_r;

  // --------------------------------------------------------------------------
  // Serial clock divider (master only)
  // --------------------------------------------------------------------------
  always_ff @(posedge CLK_I)
  begin
    if (SRST_I || state_r != ssm_pkg::SSM_SHIFT || !master_en)
    begin
      div_r <= 8'h00;
      sck_r <= 1'b0;
    end
    else if (div_r == HALF_LAST)
    begin
      div_r <= 8'h00;
      sck_r <= ~sck_r;
    end
    else
      div_r <= div_r + 8'h01;
  end

  // --------------------------------------------------------------------------
  // Shift engine: sample on the rising edge, shift on the falling edge
  // --------------------------------------------------------------------------
  always_ff @(posedge CLK_I)
  begin
    if (SRST_I)
    begin
      state_r <= ssm_pkg::SSM_IDLE;
      sh_r    <= `SSM_BYTE_RST;
      samp_r  <= 1'b0;
      bit_r   <= 3'h0;
    end
    else
    begin
      unique case (state_r)
        ssm_pkg::SSM_IDLE:
        begin
          if (load)
          begin
            // An empty buffer in slave mode sends zeros.
            sh_r    <= tx_empty_r ? `SSM_BYTE_RST : tx_buf_r;
            bit_r   <= 3'h0;
            state_r <= ssm_pkg::SSM_SHIFT;
          end
        end
        ssm_pkg::SSM_SHIFT:
        begin
          if (abort)
            state_r <= ssm_pkg::SSM_IDLE;
          else
          begin
            if (rise)
              samp_r <= in_bit;
            if (fall)
            begin
              sh_r  <= {sh_r[`SSM_DATA_W-2:0], samp_r};
              bit_r <= bit_r + 3'h1;
              if (bit_r == `SSM_BIT_LAST)
                state_r <= ssm_pkg::SSM_IDLE;
            end
          end
        end
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Received byte
  // --------------------------------------------------------------------------
  always_ff @(posedge CLK_I)
  begin
    if (SRST_I)
    begin
      RX_DATA_O  <= `SSM_BYTE_RST;
      RX_VALID_O <= 1'b0;
    end
    else
    begin
      RX_VALID_O <= last_fall;
      if (last_fall)
        RX_DATA_O <= {sh_r[`SSM_DATA_W-2:0], samp_r};
    end
  end

  // --------------------------------------------------------------------------
  // Pin drivers
  // --------------------------------------------------------------------------
  // Every pin output is registered, which adds one cycle of lag; at five
  // cycles per half period this costs nothing in margin.
  always_ff @(posedge CLK_I)
  begin
    if (SRST_I)
    begin
      SCK_O     <= 1'b0;
      SCK_OE_O  <= 1'b0;
      MOSI_O    <= 1'b0;
      MOSI_OE_O <= 1'b0;
      MISO_O    <= 1'b0;
      MISO_OE_O <= 1'b0;
      SSEL_O    <= 1'b1;
      SSEL_OE_O <= 1'b0;
      BUSY_O    <= 1'b0;
    end
    else
    begin
      SCK_O     <= sck_r;
      SCK_OE_O  <= master_en;
      MOSI_O    <= sh_r[`SSM_DATA_W-1];
      MOSI_OE_O <= master_en;
      MISO_O    <= sh_r[`SSM_DATA_W-1];
      MISO_OE_O <= slave_sel;
      SSEL_O    <= MODE_I[`SSM_MODE_MASTER_BIT] ? MODE_I[0] : 1'b1;
      SSEL_OE_O <= ENABLE_I & MODE_I[`SSM_MODE_MASTER_BIT];
      BUSY_O    <= (state_r == ssm_pkg::SSM_SHIFT);
    end
  end

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  sequence seq_off;
    !ENABLE_I [*2];
  endsequence

  sequence seq_master_frame;
    (state_r == ssm_pkg::SSM_SHIFT) ##[1:200] ((state_r == ssm_pkg::SSM_IDLE) || !master_en);
  endsequence

  a_mode_three_wire: assert property (@(posedge CLK_I) disable iff (SRST_I)
    (MODE_I == `SSM_MODE_3WIRE) |=> !SSEL_OE_O)
    else $error("Select pin driven in three-wire mode.");

  a_mode_four_in: assert property (@(posedge CLK_I) disable iff (SRST_I)
    (MODE_I == `SSM_MODE_4WIRE_IN) |=> !SSEL_OE_O)
    else $error("Select pin driven in four-wire input mode.");

  a_mode_master_drive: assert property (@(posedge CLK_I) disable iff (SRST_I)
    (ENABLE_I && MODE_I[1]) |=> (SSEL_OE_O && SSEL_O == $past(MODE_I[0])))
    else $error("Select pin not driven to the low mode bit.");

  a_write_clears: assert property (@(posedge CLK_I) disable iff (SRST_I)
    TX_WR_I |=> !TX_EMPTY_O)
    else $error("Empty flag not cleared by buffer write.");

  a_load_sets: assert property (@(posedge CLK_I) disable iff (SRST_I)
    (load && !tx_empty_r && !TX_WR_I) |=> (TX_EMPTY_O && sh_r == $past(tx_buf_r)))
    else $error("Empty flag not set when byte moved to shifter.");

  a_master_frame_ends: assert property (@(posedge CLK_I) disable iff (SRST_I)
    (load && master_en && !tx_empty_r) |=> seq_master_frame)
    else $error("Master frame did not complete in time.");

  a_disable_quiet: assert property (@(posedge CLK_I) disable iff (SRST_I)
    seq_off |-> (!SCK_OE_O && !MOSI_OE_O && !MISO_OE_O && !SSEL_OE_O &&
                 state_r == ssm_pkg::SSM_IDLE))
    else $error("Port active while disabled.");

endmodule : ssm_ctrl

`default_nettype wire

// >>> ssm_peer.sv
// Behavioural serial peer: slave to the block's master, or master to the block's slave.
`timescale 1ns/1ps
`default_nettype none

module ssm_peer (
  // Wire levels
  input  wire logic sck_i,
  input  wire logic mosi_i,
  input  wire logic miso_i,
  input  wire logic ssel_i,
  input  wire logic slv_i,
  // Pins driven by the peer
  output var  logic miso_o,
  output var  logic sck_o,
  output var  logic mosi_o,
  output var  logic ssel_o
);
  logic [7:0] tx_r  = 8'h00;
  logic [7:0] got_r = 8'h00;

  initial
  begin
    miso_o = 1'b0;
    sck_o  = 1'b0;
    mosi_o = 1'b0;
    ssel_o = 1'b1;
  end

  task load(input logic [7:0] b);
    tx_r = b;
  endtask : load

  // The reply byte rotates, so back-to-back frames repeat it without a reload race.
  always @(posedge sck_i)
    if (slv_i && !ssel_i)
      got_r = {got_r[6:0], mosi_i};
  always @(negedge sck_i)
    if (slv_i && !ssel_i)
      tx_r = {tx_r[6:0], tx_r[7]};
  // A released line shows a changing level, never the last bit sent.
  always @(tx_r or ssel_i or slv_i)
    if (slv_i && !ssel_i)
      miso_o = tx_r[7];
    else
      miso_o = ~miso_o;

  // Mode 0 master with a 160 ns clock that stands still between frames.
  task xfer(input logic [7:0] b, input logic sel);
    integer i;
    #3;
    ssel_o = !sel;
    #200;
    for (i = 7; i >= 0; i--)
    begin
      mosi_o = b[i];
      #80;
      sck_o = 1'b1;
      got_r = {got_r[6:0], miso_i};
      #80;
      sck_o = 1'b0;
    end
    #200;
    ssel_o = 1'b1;
    mosi_o = ~mosi_o;
  endtask : xfer
endmodule : ssm_peer
`default_nettype wire

// >>> tb.sv
// Self-checking bench for the serial port control block.
`timescale 1ns/1ps
`default_nettype none

module tb;
  logic       clk  = 1'b0;
  logic       srst = 1'b1;
  logic [1:0] mode = 2'b01;
  logic       en   = 1'b0;
  logic       mst  = 1'b0;
  logic       wr   = 1'b0;
  logic [7:0] wd   = 8'h00;
  logic       tx_empty, rx_valid, busy, sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe, ssel_o, ssel_oe;
  logic [7:0] rx_data;
  logic       p_miso, p_sck, p_mosi, p_ssel;
  wire        sck_w, mosi_w, miso_w, ssel_w;
  int         n_fail   = 0;
  int         compares = 0;
  int         m;

  assign sck_w  = sck_oe ? sck_o : p_sck;
  assign mosi_w = mosi_oe ? mosi_o : p_mosi;
  assign miso_w = miso_oe ? miso_o : p_miso;
  assign ssel_w = ssel_oe ? ssel_o : p_ssel;

  always #10 clk = ~clk;

  ssm_ctrl dut (.CLK_I(clk), .SRST_I(srst), .MODE_I(mode), .ENABLE_I(en), .MASTER_I(mst),
    .TX_WR_I(wr), .TX_DATA_I(wd), .TX_EMPTY_O(tx_empty), .RX_DATA_O(rx_data), .RX_VALID_O(rx_valid),
    .BUSY_O(busy), .SCK_I(sck_w), .SCK_O(sck_o), .SCK_OE_O(sck_oe), .MOSI_I(mosi_w), .MOSI_O(mosi_o),
    .MOSI_OE_O(mosi_oe), .MISO_I(miso_w), .MISO_O(miso_o), .MISO_OE_O(miso_oe), .SSEL_I(ssel_w),
    .SSEL_O(ssel_o), .SSEL_OE_O(ssel_oe));

  ssm_peer peer (.sck_i(sck_w), .mosi_i(mosi_w), .miso_i(miso_w), .ssel_i(ssel_w), .slv_i(sck_oe),
    .miso_o(p_miso), .sck_o(p_sck), .mosi_o(p_mosi), .ssel_o(p_ssel));

  // --------------------------------------------------------------------------
  // Checks and access tasks
  // --------------------------------------------------------------------------
  task conclude;
    $display("comparisons %0d, mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : conclude

  task chk1(input string nm, input logic e, input logic g);
    compares++;
    if (g !== e)
    begin
      n_fail++;
      $display("unexpected %s: expected %b, seen %b", nm, e, g);
    end
  endtask : chk1

  task chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e)
    begin
      n_fail++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask : chk8

  task write(input logic [7:0] b);
    @(posedge clk);
    wr <= 1'b1;
    wd <= b;
    @(posedge clk);
    wr <= 1'b0;
    #1;
    chk1("empty after write", 1'b0, tx_empty);
  endtask : write

  // Waits for the empty flag (which 0) or the receive pulse (which 1).
  task wait_for(input int which, input int bound);
    int i;
    for (i = 0; i < bound; i++)
    begin
      @(posedge clk);
      #1;
      if ((which == 0 ? tx_empty : rx_valid) === 1'b1)
        return;
    end
    n_fail++;
    $display("unexpected wait %0d: expected 1, seen timeout", which);
    conclude;
  endtask : wait_for

  initial
  begin
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    en   <= 1'b1;
    #1;
    chk1("empty at reset", 1'b1, tx_empty);
    chk1("ssel drive at reset", 1'b0, ssel_oe);
    for (m = 0; m < 4; m++)
    begin
      @(posedge clk);
      mode <= m[1:0];
      repeat (3) @(posedge clk);
      #1;
      chk1("ssel drive", m[1], ssel_oe);
      if (m[1])
        chk1("ssel level", m[0], ssel_o);
    end
    @(posedge clk);
    en   <= 1'b0;
    mode <= 2'b10;
    mst  <= 1'b1;
    write(8'hA5);
    repeat (20) @(posedge clk);
    #1;
    chk1("empty while off", 1'b0, tx_empty);
    chk1("ssel drive while off", 1'b0, ssel_oe);
    chk1("clock drive while off", 1'b0, sck_oe);
    peer.load(8'h3C);
    @(posedge clk);
    en <= 1'b1;
    wait_for(0, 10);
    write(8'h96);
    chk1("busy in frame", 1'b1, busy);
    wait_for(1, 200);
    chk8("master rx", 8'h3C, rx_data);
    chk8("master tx", 8'hA5, peer.got_r);
    wait_for(0, 200);
    wait_for(1, 200);
    chk8("master rx 2", 8'h3C, rx_data);
    chk8("master tx 2", 8'h96, peer.got_r);
    @(posedge clk);
    #1;
    chk1("busy after frame", 1'b0, busy);
    for (m = 1; m >= 0; m--)
    begin
      @(posedge clk);
      en   <= 1'b0;
      mst  <= 1'b0;
      mode <= m[1:0];
      write(8'h5A);
      @(posedge clk);
      en <= 1'b1;
      fork
        peer.xfer(m[0] ? 8'hC3 : 8'h3C, m[0]);
        wait_for(1, 300);
      join
      chk8("slave rx", m[0] ? 8'hC3 : 8'h3C, rx_data);
      chk8("slave tx", 8'h5A, peer.got_r);
    end
    conclude;
  end
endmodule : tb
`default_nettype wire
